// ### src/rxcs_top.sv
// Receive checksum offload: sums, checks, descriptor field and registers
//
// Our own choice: strobed register access.
`timescale 1ns/1ps

module rxcs_top (
  input  wire logic                        I_CLK,
  input  wire logic                        I_SYS_RST,
  input  wire logic [rxcs_pkg::ADDR_W-1:0] I_ADDR,
  input  wire logic [31:0]                 I_WDATA,
  input  wire logic                        I_WR,
  input  wire logic                        I_RD,
  output logic      [31:0]                 O_RDATA,
  input  wire logic                        I_RX_VALID,
  input  wire logic                        I_RX_SOP,
  input  wire logic                        I_RX_EOP,
  input  wire logic [7:0]                  I_RX_DATA,
  input  wire logic                        I_RX_VLAN,
  input  wire logic                        I_RX_FCS,
  input  wire logic                        I_RX_IP_HDR,
  input  wire logic                        I_RX_IP_PAYLOAD,
  input  wire logic                        I_RX_ETH_OK,
  input  wire logic                        I_RX_IPV4,
  input  wire logic                        I_RX_IPV6,
  input  wire logic                        I_RX_L4_OK,
  input  wire logic [15:0]                 I_RX_PSEUDO,
  input  wire logic [15:0]                 I_RX_IP_ID,
  input  wire logic [31:0]                 I_RSS_HASH,
  output logic                             O_DESC_VALID,
  output logic      [31:0]                 O_DESC_FIELD,
  output logic                             O_DESC_IPCS,
  output logic                             O_DESC_L4CS,
  output logic                             O_DESC_IPE,
  output logic                             O_DESC_TRANSPORT_ERROR_FLAG,
  output logic                             O_DESC_FRAME_CRC_ERROR_FLAG,
  output logic                             O_IRQ
);
  import rxcs_pkg::*;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  // Register state
  logic [31:0]     ctrl_q;
  logic [31:0]     aux_q;
  logic [EV_W-1:0] stat_q;
  logic [EV_W-1:0] mask_q;
  logic [31:0]     rdata_q;

  // Decoded configuration
  logic [START_W-1:0] csum_start_offset;
  logic               ip_header_check_enable;
  logic               transport_check_enable;
  logic               frame_crc_check_enable;
  logic               payload_csum_enable;
  logic               csum_report_disable;
  rxcs_fmt_type       descriptor_format;
  logic               strip_fcs;
  logic               vlan_tag_strip_enable;
  logic               v6_filter_disable;
  logic               v6_transport_check_disable;

  // Packet path state
  logic        sop;
  logic        eop;
  logic        counted;
  logic [15:0] pos;
  logic [15:0] pos_q;
  logic        pkt_en;
  logic [31:0] crc_q;
  logic        fin_q;
  logic        eth_ok_q;
  logic        v4_q;
  logic        v6_q;
  logic        l4_q;
  logic [15:0] pseudo_q;
  logic [15:0] ipid_q;
  logic [31:0] rss_q;

  // Result terms
  logic            ip_chk;
  logic            l4_chk;
  logic            ip_header_error_flag;
  logic            l4e;
  logic            frame_crc_error_flag;
  logic [31:0]     field;
  logic [EV_W-1:0] ev;
  logic [EV_W-1:0] w1c;

  rxcs_sum_if pkt_if ();
  rxcs_sum_if iph_if ();
  rxcs_sum_if l4_if ();

  // One CRC32 step over a byte, reflected, least bit first
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  d);
    logic [31:0] r;
    r = c ^ {24'h00_0000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  // Field decode of control and auxiliary registers
  always_comb begin
    csum_start_offset          = ctrl_q[START_LSB +: START_W];
    ip_header_check_enable     = ctrl_q[IPCHK_BIT];
    transport_check_enable     = ctrl_q[L4CHK_BIT];
    frame_crc_check_enable     = ctrl_q[CRCCHK_BIT];
    payload_csum_enable        = ctrl_q[PAYLD_BIT];
    csum_report_disable        = ctrl_q[DIS_BIT];
    descriptor_format          = rxcs_fmt_type'(aux_q[FMT_LSB +: 2]);
    strip_fcs                  = aux_q[STRIPFCS_BIT];
    vlan_tag_strip_enable      = aux_q[VLANSTRIP_BIT];
    v6_filter_disable          = aux_q[V6FILT_BIT];
    v6_transport_check_disable = aux_q[V6CSUM_BIT];
  end

  // Stream qualifiers; a stripped tag byte is not a packet byte
  assign sop     = I_RX_VALID && I_RX_SOP;
  assign eop     = I_RX_VALID && I_RX_EOP;
  assign counted = I_RX_VALID && !(I_RX_VLAN && vlan_tag_strip_enable);
  assign pos     = I_RX_SOP ? 16'h0000 : pos_q;

  // Byte selection for the packet sum
  always_comb begin
    if (payload_csum_enable) begin
      pkt_en = I_RX_VALID && I_RX_IP_PAYLOAD && !I_RX_FCS;
    end else begin
      pkt_en = counted && (pos >= {8'h00, csum_start_offset})
               && !(I_RX_FCS && strip_fcs);
    end
  end

  // Position of the next packet byte, saturating on jumbo frames
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      pos_q <= 16'h0000;
    end else if (counted && pos != 16'hFFFF) begin
      pos_q <= pos + 16'h0001;
    end else if (sop) begin
      pos_q <= 16'h0000;
    end
  end

  // Accumulator feeds
  assign pkt_if.sop  = sop;
  assign pkt_if.eop  = eop;
  assign pkt_if.en   = pkt_en;
  assign pkt_if.data = I_RX_DATA;
  assign iph_if.sop  = sop;
  assign iph_if.eop  = eop;
  assign iph_if.en   = I_RX_VALID && I_RX_IP_HDR;
  assign iph_if.data = I_RX_DATA;
  assign l4_if.sop   = sop;
  assign l4_if.eop   = eop;
  assign l4_if.en    = I_RX_VALID && I_RX_IP_PAYLOAD && !I_RX_FCS;
  assign l4_if.data  = I_RX_DATA;

  rxcs_sum u_pkt_sum (
    .i_clk     (I_CLK),
    .i_sys_rst (I_SYS_RST),
    .acc_io    (pkt_if.acc)
  );

  rxcs_sum u_iph_sum (
    .i_clk     (I_CLK),
    .i_sys_rst (I_SYS_RST),
    .acc_io    (iph_if.acc)
  );

  rxcs_sum u_l4_sum (
    .i_clk     (I_CLK),
    .i_sys_rst (I_SYS_RST),
    .acc_io    (l4_if.acc)
  );

  // CRC32 over every frame byte; a good frame leaves the residue
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      crc_q <= CRC_INIT;
    end else if (I_RX_VALID) begin
      crc_q <= crc_byte(I_RX_SOP ? CRC_INIT : crc_q, I_RX_DATA);
    end
  end

  // Packet facts sampled with the last byte
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      fin_q    <= 1'b0;
      eth_ok_q <= 1'b0;
      v4_q     <= 1'b0;
      v6_q     <= 1'b0;
      l4_q     <= 1'b0;
      pseudo_q <= 16'h0000;
      ipid_q   <= 16'h0000;
      rss_q    <= 32'h0000_0000;
    end else begin
      fin_q <= eop;
      if (eop) begin
        eth_ok_q <= I_RX_ETH_OK;
        v4_q     <= I_RX_IPV4;
        v6_q     <= I_RX_IPV6;
        l4_q     <= I_RX_L4_OK;
        pseudo_q <= I_RX_PSEUDO;
        ipid_q   <= I_RX_IP_ID;
        rss_q    <= I_RSS_HASH;
      end
    end
  end

  // Checks, gated by enables; IP and transport checks also by frame type
  always_comb begin
    ip_chk = ip_header_check_enable && eth_ok_q && v4_q;
    l4_chk = transport_check_enable && eth_ok_q && l4_q
             && (v4_q || (v6_q && !v6_filter_disable
                          && !v6_transport_check_disable));
    ip_header_error_flag    = ip_chk && (iph_if.sum != CSUM_GOOD);
    l4e    = l4_chk && (rxcs_add1c(l4_if.sum, pseudo_q) != CSUM_GOOD);
    frame_crc_error_flag   = frame_crc_check_enable && (crc_q != CRC_RESIDUE);
  end

  // Shared descriptor field: packet sum or hash, never both
  always_comb begin
    case (descriptor_format)
      FMT_LEGACY: field = {16'h0000, pkt_if.sum};
      default: begin
        if (csum_report_disable) begin
          field = rss_q;
        end else begin
          field = {ipid_q, pkt_if.sum};
        end
      end
    endcase
  end

  // Descriptor outputs, one cycle after the sums settle
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_DESC_VALID <= 1'b0;
      O_DESC_FIELD <= 32'h0000_0000;
      O_DESC_IPCS  <= 1'b0;
      O_DESC_L4CS  <= 1'b0;
      O_DESC_IPE   <= 1'b0;
      O_DESC_TRANSPORT_ERROR_FLAG  <= 1'b0;
      O_DESC_FRAME_CRC_ERROR_FLAG  <= 1'b0;
    end else begin
      O_DESC_VALID <= fin_q;
      if (fin_q) begin
        O_DESC_FIELD <= field;
        O_DESC_IPCS  <= ip_chk;
        O_DESC_L4CS  <= l4_chk;
        O_DESC_IPE   <= ip_header_error_flag;
        O_DESC_TRANSPORT_ERROR_FLAG  <= l4e;
        O_DESC_FRAME_CRC_ERROR_FLAG  <= frame_crc_error_flag;
      end
    end
  end

  // Event collection; a new event beats a same-cycle clear
  always_comb begin
    ev          = '0;
    ev[EV_DONE] = fin_q;
    ev[EV_IPE]  = fin_q && ip_header_error_flag;
    ev[EV_L4E]  = fin_q && l4e;
    ev[EV_FRAME_CRC_ERROR_FLAG] = fin_q && frame_crc_error_flag;
    w1c = (I_WR && I_ADDR == STAT_OFS) ? I_WDATA[EV_W-1:0] : '0;
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      stat_q <= EV_RESET;
    end else begin
      stat_q <= (stat_q & ~w1c) | ev;
    end
  end

  assign O_IRQ = |(stat_q & mask_q);

  // Register writes; reserved bits are dropped at the door
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ctrl_q <= CTRL_RESET;
      aux_q  <= AUX_RESET;
      mask_q <= EV_RESET;
    end else if (I_WR) begin
      case (I_ADDR)
        CTRL_OFS: ctrl_q <= I_WDATA & CTRL_WMASK;
        AUX_OFS:  aux_q  <= I_WDATA & AUX_WMASK;
        MASK_OFS: mask_q <= I_WDATA[EV_W-1:0];
        default:  ;
      endcase
    end
  end

  // Read data stand one cycle, zero otherwise and on unmapped offsets
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      rdata_q <= 32'h0000_0000;
    end else if (I_RD) begin
      case (I_ADDR)
        CTRL_OFS: rdata_q <= ctrl_q;
        AUX_OFS:  rdata_q <= aux_q;
        STAT_OFS: rdata_q <= {28'h000_0000, stat_q};
        MASK_OFS: rdata_q <= {28'h000_0000, mask_q};
        default:  rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign O_RDATA = rdata_q;

  // Checks on the packet path and descriptor
  chk_start_offset: assert property (
    (pkt_en && !payload_csum_enable) |->
      (pos >= {8'h00, csum_start_offset}))
    else $error("packet sum took a byte before the start offset");

  chk_fcs_excluded: assert property (
    (I_RX_VALID && I_RX_FCS && strip_fcs) |-> !pkt_en)
    else $error("FCS byte entered the packet sum while stripping");

  // Back-to-back short frames may overlap pulses, so check both directions
  chk_desc_timing: assert property (
    eop |-> ##2 O_DESC_VALID)
    else $error("descriptor not written two cycles after last byte");
  chk_desc_origin: assert property (
    O_DESC_VALID |-> $past(eop, 2))
    else $error("descriptor written without a last byte");

  chk_legacy_field: assert property (
    (fin_q && descriptor_format == FMT_LEGACY) |=>
      (O_DESC_FIELD == {16'h0000, $past(pkt_if.sum)}))
    else $error("legacy descriptor lacks packet sum");

  chk_ext_field: assert property (
    (fin_q && descriptor_format == FMT_EXT && !csum_report_disable) |=>
      (O_DESC_FIELD == {$past(ipid_q), $past(pkt_if.sum)}))
    else $error("extended descriptor lacks sum and identification");

  chk_rss_field: assert property (
    (fin_q && descriptor_format == FMT_EXT && csum_report_disable) |=>
      (O_DESC_FIELD == $past(rss_q)))
    else $error("hash not reported with reporting disabled");

  chk_ip_gate: assert property (
    (O_DESC_VALID && O_DESC_IPE) |->
      ($past(ip_header_check_enable) && O_DESC_IPCS))
    else $error("IP error flagged while header check off");

  chk_l4_v6_gate: assert property (
    (fin_q && !v4_q && (v6_filter_disable || v6_transport_check_disable))
      |=> !O_DESC_L4CS && !O_DESC_TRANSPORT_ERROR_FLAG)
    else $error("IPv6 transport checked while disabled");

  chk_frame_type: assert property (
    (fin_q && !eth_ok_q) |=> !O_DESC_IPE && !O_DESC_TRANSPORT_ERROR_FLAG && !O_DESC_L4CS)
    else $error("check applied to unsupported frame type");

  chk_crc_gate: assert property (
    (fin_q && !frame_crc_check_enable) |=> !O_DESC_FRAME_CRC_ERROR_FLAG)
    else $error("CRC error flagged while CRC check off");
endmodule : rxcs_top

// ### src/rxcs_pkg.sv
// Package: register map, field layout and helpers of the receive checksum block
package rxcs_pkg;
  localparam int          ADDR_W        = 16;
  // Register offsets
  localparam logic [15:0] CTRL_OFS      = 16'h5000;
  localparam logic [15:0] AUX_OFS       = 16'h5100;
  localparam logic [15:0] STAT_OFS      = 16'h5104;
  localparam logic [15:0] MASK_OFS      = 16'h5108;
  // Checksum control fields
  localparam int          START_LSB     = 0;
  localparam int          START_W       = 8;
  localparam int          IPCHK_BIT     = 8;
  localparam int          L4CHK_BIT     = 9;
  localparam int          CRCCHK_BIT    = 11;
  localparam int          PAYLD_BIT     = 12;
  localparam int          DIS_BIT       = 13;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0300;
  localparam logic [31:0] CTRL_WMASK    = 32'h0000_3BFF;
  // Auxiliary receive configuration fields
  localparam int          FMT_LSB       = 0;
  localparam int          STRIPFCS_BIT  = 2;
  localparam int          VLANSTRIP_BIT = 3;
  localparam int          V6FILT_BIT    = 4;
  localparam int          V6CSUM_BIT    = 5;
  localparam logic [31:0] AUX_RESET     = 32'h0000_0000;
  localparam logic [31:0] AUX_WMASK     = 32'h0000_003F;
  // Event bits of status and mask
  localparam int          EV_DONE       = 0;
  localparam int          EV_IPE        = 1;
  localparam int          EV_L4E        = 2;
  localparam int          EV_FRAME_CRC_ERROR_FLAG       = 3;
  localparam int          EV_W          = 4;
  localparam logic [3:0]  EV_RESET      = 4'h0;
  // Checksum and CRC constants
  localparam logic [15:0] CSUM_GOOD     = 16'hFFFF;
  localparam logic [31:0] CRC_INIT      = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY      = 32'hEDB8_8320;
  // Good-frame residue as the shift-right register holds it, not inverted
  localparam logic [31:0] CRC_RESIDUE   = 32'hDEBB_20E3;

  typedef enum logic [1:0] {
    FMT_LEGACY = 2'b00,
    FMT_EXT    = 2'b01
  } rxcs_fmt_type;

  // Ones' complement add with end-around carry
  function automatic logic [15:0] rxcs_add1c(input logic [15:0] a,
                                             input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction : rxcs_add1c
endpackage : rxcs_pkg

// ### src/rxcs_sum_if.sv
// Interface: byte feed into one ones' complement accumulator
`timescale 1ns/1ps
interface rxcs_sum_if;
  logic        sop;
  logic        eop;
  logic        en;
  logic [7:0]  data;
  logic [15:0] sum;
  modport feed (output sop, output eop, output en, output data, input sum);
  modport acc  (input sop, input eop, input en, input data, output sum);
endinterface : rxcs_sum_if

// ### src/rxcs_sum.sv
// Byte-wide 16-bit ones' complement accumulator
`timescale 1ns/1ps
module rxcs_sum (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  rxcs_sum_if.acc  acc_io
);
  import rxcs_pkg::*;

  logic [15:0] acc_q;
  logic [7:0]  hi_q;
  logic        pend_q;
  logic [15:0] base;
  logic        base_pend;

  // Start of packet drops the old sum even on an uncounted byte
  always_comb begin
    base      = acc_io.sop ? 16'h0000 : acc_q;
    base_pend = acc_io.sop ? 1'b0 : pend_q;
  end

  // High byte first; a lone trailing byte is padded with zero
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      acc_q  <= 16'h0000;
      hi_q   <= 8'h00;
      pend_q <= 1'b0;
    end else if (acc_io.en) begin
      if (base_pend) begin
        acc_q  <= rxcs_add1c(base, {hi_q, acc_io.data});
        pend_q <= 1'b0;
      end else if (acc_io.eop) begin
        acc_q  <= rxcs_add1c(base, {acc_io.data, 8'h00});
        pend_q <= 1'b0;
      end else begin
        acc_q  <= base;
        hi_q   <= acc_io.data;
        pend_q <= 1'b1;
      end
    end else if (acc_io.eop && base_pend) begin
      acc_q  <= rxcs_add1c(base, {hi_q, 8'h00});
      pend_q <= 1'b0;
    end else begin
      acc_q  <= base;
      pend_q <= base_pend;
    end
  end

  assign acc_io.sum = acc_q;
endmodule : rxcs_sum

// ### testbench/rxcs_src_model.sv
// Model of the receive packet path feeding the checksum block
`timescale 1ns/1ps
module rxcs_src_model (
  input  wire logic i_clk,
  output logic        o_valid,
  output logic        o_sop,
  output logic        o_eop,
  output logic [7:0]  o_data,
  output logic [3:0]  o_kind,
  output logic [3:0]  o_flags,
  output logic [15:0] o_pseudo,
  output logic [15:0] o_ip_id,
  output logic [31:0] o_hash
);
  // Frame image; kind bits: tag, fcs, ip header, ip payload
  logic [7:0] fb [0:31];
  logic [3:0] fk [0:31];
  int         flen = 0;

  // Idle levels at time zero
  initial begin
    o_valid  = 1'b0;
    o_sop    = 1'b0;
    o_eop    = 1'b0;
    o_data   = 8'h00;
    o_kind   = 4'h0;
    o_flags  = 4'h0;
    o_pseudo = 16'h0000;
    o_ip_id  = 16'h0000;
    o_hash   = 32'h0000_0000;
  end

  // One byte a cycle, no gaps; frame facts held until next frame
  task automatic send(input logic [3:0] fl, input logic [15:0] ps,
                      input logic [15:0] id, input logic [31:0] hs);
    for (int i = 0; i < flen; i++) begin
      @(posedge i_clk);
      o_valid  <= 1'b1;
      o_sop    <= (i == 0);
      o_eop    <= (i == flen - 1);
      o_data   <= fb[i];
      o_kind   <= fk[i];
      o_flags  <= fl;
      o_pseudo <= ps;
      o_ip_id  <= id;
      o_hash   <= hs;
    end
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_sop   <= 1'b0;
    o_eop   <= 1'b0;
    o_kind  <= 4'h0;
    // Released data shows the inverse, never a stale copy
    o_data  <= ~fb[flen-1];
  endtask : send
endmodule : rxcs_src_model

// ### testbench/rx_checksum_offload_test.sv
// Self-checking bench of the receive checksum block
`timescale 1ns/1ps
module rx_checksum_offload_test;
  import rxcs_pkg::*;
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic        wr    = 1'b0;
  logic        rd    = 1'b0;
  logic [15:0] addr  = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata, field, hs, f;
  logic [15:0] ps, id;
  logic        valid, sop, eop, dv, ipcs, l4cs, ip_header_error_flag, transport_error_flag, frame_crc_error_flag, irq;
  logic [7:0]  data;
  logic [3:0]  kind, fl;
  int          fails    = 0;
  int          n_checks = 0;

  always #50 clk = ~clk;

  rxcs_src_model i_src (.i_clk(clk), .o_valid(valid), .o_sop(sop),
    .o_eop(eop), .o_data(data), .o_kind(kind), .o_flags(fl),
    .o_pseudo(ps), .o_ip_id(id), .o_hash(hs));

  rxcs_top i_dut (.I_CLK(clk), .I_SYS_RST(rst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_RX_VALID(valid), .I_RX_SOP(sop), .I_RX_EOP(eop),
    .I_RX_DATA(data), .I_RX_VLAN(kind[0]), .I_RX_FCS(kind[1]),
    .I_RX_IP_HDR(kind[2]), .I_RX_IP_PAYLOAD(kind[3]),
    .I_RX_ETH_OK(fl[3]), .I_RX_IPV4(fl[2]), .I_RX_IPV6(fl[1]),
    .I_RX_L4_OK(fl[0]), .I_RX_PSEUDO(ps), .I_RX_IP_ID(id),
    .I_RSS_HASH(hs), .O_DESC_VALID(dv), .O_DESC_FIELD(field),
    .O_DESC_IPCS(ipcs), .O_DESC_L4CS(l4cs), .O_DESC_IPE(ip_header_error_flag),
    .O_DESC_TRANSPORT_ERROR_FLAG(transport_error_flag), .O_DESC_FRAME_CRC_ERROR_FLAG(frame_crc_error_flag), .O_IRQ(irq));

  task automatic final_report;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wreg(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wreg

  // Read data stands only in the cycle after the strobe
  task automatic rreg(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(rdata, e);
  endtask : rreg

  // Own end-around-carry add, kept apart from the design's helper
  function automatic logic [15:0] add(input logic [15:0] a, b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction : add

  // Expected packet sum: high byte first, odd byte padded low
  function automatic logic [15:0] esum(input int st, input logic vs,
                                       input logic fs, input logic pm);
    logic [15:0] s;
    logic [15:0] w;
    int          p;
    int          n;
    s = 16'h0000;
    w = 16'h0000;
    p = 0;
    n = 0;
    for (int i = 0; i < i_src.flen; i++) begin
      if (!(vs && i_src.fk[i][0])) begin
        if ((pm ? i_src.fk[i][3] : p >= st) && !(fs && i_src.fk[i][1]))
        begin
          if (n % 2 == 1) s = add(s, {w[15:8], i_src.fb[i]});
          else w = {i_src.fb[i], 8'h00};
          n++;
        end
        p++;
      end
    end
    if (n % 2 == 1) s = add(s, w);
    return s;
  endfunction : esum

  function automatic logic [31:0] crc(input int n);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    for (int i = 0; i < n; i++) begin
      c = c ^ {24'h00_0000, i_src.fb[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction : crc

  task automatic put4(input logic [31:0] v, input logic [3:0] k);
    for (int i = 0; i < 4; i++) begin
      i_src.fb[i_src.flen] = v[31-8*i -: 8];
      i_src.fk[i_src.flen] = k;
      i_src.flen++;
    end
  endtask : put4

  // Frame: 2 bytes, optional tag, 4-byte header, 3 payload, FCS
  task automatic build(input logic vl, input logic bip, input logic bfc);
    logic [31:0] c;
    i_src.flen = 0;
    put4(32'h00AA_55_00, 4'h0);
    i_src.flen = 2;
    if (vl) put4(32'h8100_0005, 4'h1);
    put4(bip ? 32'h1234_ECCB : 32'h1234_EDCB, 4'h4);
    put4(32'h0102_0300, 4'h8);
    i_src.flen--;
    c = crc(i_src.flen);
    put4({c[7:0] ^ {8{bfc}}, c[15:8], c[23:16], c[31:24]}, 4'h2);
  endtask : build

  // Descriptor pulse two cycles after the last byte, then fields
  task automatic frame(input logic [3:0] f4, input logic [15:0] p,
                       input logic [31:0] ef, input logic [4:0] eg);
    i_src.send(f4, p, 16'hBEEF, 32'hA5C3_0F96);
    @(posedge clk);
    #1;
    chk({31'h0000_0000, dv}, 32'h0000_0001);
    chk(field, ef);
    chk({27'h000_0000, ipcs, l4cs, ip_header_error_flag, transport_error_flag, frame_crc_error_flag}, {27'h000_0000, eg});
  endtask : frame

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #3_000_000;
    fails++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rreg(CTRL_OFS, 32'h0000_0300);
    rreg(AUX_OFS, 32'h0000_0000);
    rreg(STAT_OFS, 32'h0000_0000);
    rreg(MASK_OFS, 32'h0000_0000);
    wreg(CTRL_OFS, 32'hFFFF_FFFF);
    rreg(CTRL_OFS, 32'h0000_3BFF);
    wreg(16'h5004, 32'hFFFF_FFFF);
    rreg(16'h5004, 32'h0000_0000);
    $display("test registers done");
    // Start at the IP header, written while no frame is moving
    wreg(CTRL_OFS, 32'h0000_0B02);
    wreg(AUX_OFS, 32'h0000_0000);
    build(1'b0, 1'b0, 1'b0);
    frame(4'hD, 16'hFBFD, {16'h0000, esum(2, 0, 0, 0)}, 5'h18);
    wreg(AUX_OFS, 32'h0000_000C);
    build(1'b1, 1'b1, 1'b1);
    frame(4'hD, 16'hFBFD, {16'h0000, esum(2, 1, 1, 0)}, 5'h1D);
    rreg(STAT_OFS, 32'h0000_000B);
    $display("test legacy sum done");
    wreg(CTRL_OFS, 32'h0000_0B00);
    wreg(AUX_OFS, 32'h0000_0001);
    build(1'b1, 1'b0, 1'b0);
    frame(4'hD, 16'hFBFD, {16'hBEEF, esum(0, 0, 0, 0)}, 5'h18);
    wreg(CTRL_OFS, 32'h0000_2B00);
    frame(4'hD, 16'hFBFD, 32'hA5C3_0F96, 5'h18);
    $display("test extended done");
    wreg(CTRL_OFS, 32'h0000_1B07);
    wreg(AUX_OFS, 32'h0000_0000);
    build(1'b0, 1'b0, 1'b0);
    f = {16'h0000, esum(7, 0, 0, 1)};
    frame(4'hD, 16'hFBFD, f, 5'h18);
    wreg(AUX_OFS, 32'h0000_0010);
    frame(4'hB, 16'hFBFD, f, 5'h00);
    wreg(AUX_OFS, 32'h0000_0000);
    frame(4'hB, 16'hFBFC, f, 5'h0A);
    frame(4'h5, 16'hFBFD, f, 5'h00);
    rreg(STAT_OFS, 32'h0000_000F);
    // CRC check off: a broken FCS must not be flagged
    wreg(CTRL_OFS, 32'h0000_1307);
    build(1'b0, 1'b0, 1'b1);
    frame(4'hD, 16'hFBFD, f, 5'h18);
    $display("test checks done");
    wreg(STAT_OFS, 32'h0000_000F);
    rreg(STAT_OFS, 32'h0000_0000);
    wreg(MASK_OFS, 32'h0000_0002);
    frame(4'hD, 16'hFBFD, f, 5'h18);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    wreg(MASK_OFS, 32'h0000_0001);
    #1 chk({31'h0000_0000, irq}, 32'h0000_0001);
    rreg(STAT_OFS, 32'h0000_0001);
    wreg(STAT_OFS, 32'h0000_0001);
    #1 chk({31'h0000_0000, irq}, 32'h0000_0000);
    rreg(STAT_OFS, 32'h0000_0000);
    $display("test interrupt done");
    final_report();
  end
endmodule : rx_checksum_offload_test
